// ---- rtl/rrcap_capability_regs.sv ----
`timescale 1ns/1ps
`include "rrcap_consts.svh"
// How it works
// - Freeze bit 7 blocks control-channel loading of capability values.
// - While frozen, 0x20 holds what software last wrote; 0x21 keeps its last software write or channel load.
// - Unfrozen fields load from the control channel after receive lock on that port.
// - Bit 6 is mode code bit 0; bits 2:1 sit in register 0x21.
// - Bit 5 set requests the frequency training pattern on that link.
// - Bit 4 set requests the equalizer training pattern on that link.
// - Bit 3 reports the remote receiver is two-link capable.
// - Bit 2 names the channel: 0 primary, 1 secondary.
// - Bit 1 reports 24-bit video together with high-quality audio.
// - Bit 0 reports GPIO support in the forward frame.
// - Separate copies per port; port 1 copy used when its select bit is set.
// - Port select ignored while secondary address enabled; address then chooses port.
// - Mode code 000 normal frame, 001 and 010 fast GPIO with one/two.
module rrcap_capability_regs
(
   input  wire logic                      ref_clk,
   input  wire logic                      srst,
   input  wire rrcap_pkg::rrcap_req_t     req,
   output rrcap_pkg::rrcap_rsp_t          rsp,
   input  wire logic                      second_port_select,
   input  wire logic                      secondary_address_enable,
   input  wire logic [1:0]                rx_lock,
   input  wire logic [1:0]                caps_valid,
   input  wire rrcap_pkg::rrcap_caps_t    caps_port0,
   input  wire rrcap_pkg::rrcap_caps_t    caps_port1,
   output rrcap_pkg::rrcap_port_out_t     port0_out,
   output rrcap_pkg::rrcap_port_out_t     port1_out
);
   import rrcap_pkg::*;

   rrcap_state_t s_q;
   rrcap_state_t s_d;

   function automatic logic [7:0] caps_to_low(input rrcap_caps_t c, input logic frz);
      caps_to_low = {frz, c.fast_control_channel_code[0], c.frequency_training_request,
                     c.equalizer_training_request, c.two_link_capable, c.secondary_channel,
                     c.wide_video_with_hq_audio, c.forward_frame_gpio_support};
   endfunction

   function automatic rrcap_port_out_t unpack_port(input logic [7:0] lo, input logic [1:0] hi);
      rrcap_port_out_t o;
      o.capability_freeze          = lo[`RRCAP_BIT_FREEZE];
      o.fast_control_channel_code  = rrcap_code_t'({hi, lo[`RRCAP_BIT_CODE0]});
      o.frequency_training_request = lo[`RRCAP_BIT_FREQ_TRAIN];
      o.equalizer_training_request = lo[`RRCAP_BIT_EQ_TRAIN];
      o.two_link_capable           = lo[`RRCAP_BIT_TWO_LINK];
      o.secondary_channel          = lo[`RRCAP_BIT_CHANNEL];
      o.wide_video_with_hq_audio   = lo[`RRCAP_BIT_WIDE_VIDEO];
      o.forward_frame_gpio_support = lo[`RRCAP_BIT_FWD_GPIO];
      unpack_port = o;
   endfunction

   // Second address, when enabled, overrides the primary-address select
   function automatic logic select_port(input logic sec_en, input logic via_sec, input logic sel);
      logic pick;
      pick = sel;
      if (sec_en)
      begin
         pick = via_sec;
      end
      select_port = pick;
   endfunction

   function automatic logic addr_is_low(input logic [7:0] a);
      addr_is_low = (a == `RRCAP_ADDR_CAP_LOW);
   endfunction

   function automatic logic addr_is_high(input logic [7:0] a);
      addr_is_high = (a == `RRCAP_ADDR_CAP_HIGH);
   endfunction

   // Edge, not level: a lock held across a freeze clear must not rearm
   function automatic logic arm_on_edge(input logic lock, input logic lock_prev, input logic frz);
      arm_on_edge = lock && !lock_prev && !frz;
   endfunction

   function automatic logic load_allowed(input logic armed, input logic lock, input logic valid,
                                         input logic frz);
      load_allowed = armed && lock && valid && !frz;
   endfunction

   always_comb
   begin
      logic        port;
      logic        frz;
      rrcap_caps_t c;
      port = 1'b0;
      frz  = 1'b0;
      c    = '0;
      s_d  = s_q;
      // Address route decides the copy when the second address is on
      port = select_port(secondary_address_enable, req.via_secondary_address, second_port_select);
      for (int p = 0; p < 2; p++)
      begin
         frz = s_q.cap_low[p][`RRCAP_BIT_FREEZE];
         c   = (p == 0) ? caps_port0 : caps_port1;
         s_d.lock_seen[p] = rx_lock[p];
         // Arm on a fresh lock edge only, so clearing freeze waits for relock
         if (arm_on_edge(rx_lock[p], s_q.lock_seen[p], frz))
         begin
            s_d.armed[p] = 1'b1;
         end
         if (frz || !rx_lock[p])
         begin
            s_d.armed[p] = 1'b0;
         end
         if (load_allowed(s_q.armed[p], rx_lock[p], caps_valid[p], frz))
         begin
            s_d.cap_low[p]  = caps_to_low(c, 1'b0);
            s_d.cap_high[p] = c.fast_control_channel_code[2:1];
         end
      end
      // Software write applied last: same-cycle write beats a channel load
      if (req.wr)
      begin
         if (addr_is_low(req.addr))
         begin
            s_d.cap_low[port] = req.wdata;
            if (req.wdata[`RRCAP_BIT_FREEZE])
            begin
               s_d.armed[port] = 1'b0;
            end
         end
         else if (addr_is_high(req.addr))
         begin
            s_d.cap_high[port] = req.wdata[1:0];
         end
      end
      s_d.rsp_hit  = 1'b0;
      s_d.rsp_data = `RRCAP_UNMAPPED_DATA;
      if (req.rd)
      begin
         if (addr_is_low(req.addr))
         begin
            s_d.rsp_hit  = 1'b1;
            s_d.rsp_data = s_q.cap_low[port];
         end
         else if (addr_is_high(req.addr))
         begin
            s_d.rsp_hit  = 1'b1;
            s_d.rsp_data = {6'h00, s_q.cap_high[port]};
         end
         else
         begin
            s_d.rsp_hit  = 1'b0;
            s_d.rsp_data = `RRCAP_UNMAPPED_DATA;
         end
      end
      if (srst)
      begin
         s_d.cap_low   = {`RRCAP_CAP_LOW_RESET, `RRCAP_CAP_LOW_RESET};
         s_d.cap_high  = {`RRCAP_CAP_HIGH_RESET, `RRCAP_CAP_HIGH_RESET};
         s_d.armed     = 2'h0;
         s_d.lock_seen = 2'h0;
         s_d.rsp_hit   = 1'b0;
         s_d.rsp_data  = `RRCAP_UNMAPPED_DATA;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      s_q <= s_d;
   end

   // One driver for the whole response word
   assign rsp       = {s_q.rsp_hit, s_q.rsp_data};
   assign port0_out = unpack_port(s_q.cap_low[0], s_q.cap_high[0]);
   assign port1_out = unpack_port(s_q.cap_low[1], s_q.cap_high[1]);

endmodule

// ---- rtl/rrcap_consts.svh ----
`ifndef RRCAP_CONSTS_SVH
`define RRCAP_CONSTS_SVH

`define RRCAP_ADDR_CAP_LOW      8'h20
`define RRCAP_ADDR_CAP_HIGH     8'h21
`define RRCAP_CAP_LOW_RESET     8'h00
`define RRCAP_CAP_HIGH_RESET    2'h0
`define RRCAP_UNMAPPED_DATA     8'h00

`define RRCAP_BIT_FREEZE        7
`define RRCAP_BIT_CODE0         6
`define RRCAP_BIT_FREQ_TRAIN    5
`define RRCAP_BIT_EQ_TRAIN      4
`define RRCAP_BIT_TWO_LINK      3
`define RRCAP_BIT_CHANNEL       2
`define RRCAP_BIT_WIDE_VIDEO    1
`define RRCAP_BIT_FWD_GPIO      0

`endif

// ---- rtl/rrcap_pkg.sv ----
package rrcap_pkg;

   typedef enum logic [2:0]
   {
      RRCAP_CODE_NORMAL_FRAME = 3'b000,
      RRCAP_CODE_FAST_GPIO_1  = 3'b001,
      RRCAP_CODE_FAST_GPIO_2  = 3'b010,
      RRCAP_CODE_FAST_GPIO_4  = 3'b011,
      RRCAP_CODE_RSVD_4       = 3'b100,
      RRCAP_CODE_RSVD_5       = 3'b101,
      RRCAP_CODE_FWD_SPI      = 3'b110,
      RRCAP_CODE_REV_SPI      = 3'b111
   } rrcap_code_t;

   // Capability word as delivered by the control channel
   typedef struct packed
   {
      logic [2:0] fast_control_channel_code;
      logic       frequency_training_request;
      logic       equalizer_training_request;
      logic       two_link_capable;
      logic       secondary_channel;
      logic       wide_video_with_hq_audio;
      logic       forward_frame_gpio_support;
   } rrcap_caps_t;

   typedef struct packed
   {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
      logic       via_secondary_address;
   } rrcap_req_t;

   typedef struct packed
   {
      logic       hit;
      logic [7:0] rdata;
   } rrcap_rsp_t;

   typedef struct packed
   {
      logic        capability_freeze;
      rrcap_code_t fast_control_channel_code;
      logic        frequency_training_request;
      logic        equalizer_training_request;
      logic        two_link_capable;
      logic        secondary_channel;
      logic        wide_video_with_hq_audio;
      logic        forward_frame_gpio_support;
   } rrcap_port_out_t;

   typedef struct packed
   {
      logic [1:0][7:0] cap_low;
      logic [1:0][1:0] cap_high;
      logic [1:0]      armed;
      logic [1:0]      lock_seen;
      logic            rsp_hit;
      logic [7:0]      rsp_data;
   } rrcap_state_t;

endpackage

// ---- testbench/rrcap_capability_regs_checker.sv ----
`timescale 1ns/1ps
module rrcap_capability_regs_checker
(
   input wire logic                       ref_clk,
   input wire logic                       srst,
   input wire rrcap_pkg::rrcap_req_t      req,
   input wire rrcap_pkg::rrcap_rsp_t      rsp,
   input wire logic                       second_port_select,
   input wire logic                       secondary_address_enable,
   input wire logic [1:0]                 rx_lock,
   input wire logic [1:0]                 caps_valid,
   input wire rrcap_pkg::rrcap_caps_t     caps_port0,
   input wire rrcap_pkg::rrcap_caps_t     caps_port1,
   input wire rrcap_pkg::rrcap_port_out_t port0_out,
   input wire rrcap_pkg::rrcap_port_out_t port1_out
);
   import rrcap_pkg::*;
   logic       p;
   logic [7:0] low0;
   logic [7:0] hi1;
   assign p = secondary_address_enable ? req.via_secondary_address : second_port_select;
   assign low0 = {port0_out[9], port0_out[6:0]};
   assign hi1 = {6'h00, port1_out[8:7]};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   a_rsp_idle: assert property (!req.rd |=> rsp == 9'h000) else $error("rsp not idle");
   a_freeze_holds: assert property (port0_out.capability_freeze && !req.wr |=> $stable(port0_out))
      else $error("frozen copy changed");
   a_nolock_holds: assert property (!rx_lock[1] && !req.wr |=> $stable(port1_out))
      else $error("load w/o lock");
   a_load_lands: assert property ($rose(rx_lock[0]) ##1
      (caps_valid[0] && !port0_out.capability_freeze && !req.wr) |=> port0_out == {1'b0, $past(caps_port0)})
      else $error("load missed");
   a_low_write: assert property (req.wr && req.addr == 8'h20 && !p |=> low0 == $past(req.wdata))
      else $error("port0 write lost");
   a_port1_write: assert property (req.wr && req.addr == 8'h20 && p |=> {port1_out[9], port1_out[6:0]}
      == $past(req.wdata)) else $error("port1 write lost");
   a_high_write: assert property (req.wr && req.addr == 8'h21 && !p |=> {6'h00, port0_out[8:7]}
      == ($past(req.wdata) & 8'h03)) else $error("code write lost");
   a_read_low: assert property (req.rd && req.addr == 8'h20 && !p |=> rsp == {1'b1, $past(low0)})
      else $error("bad low read");
   a_read_high: assert property (req.rd && req.addr == 8'h21 && p |=> rsp == {1'b1, $past(hi1)})
      else $error("bad high read");
   cover property (caps_valid[0] && rx_lock[0]);
   cover property (req.wr && secondary_address_enable);
   cover property (port0_out.capability_freeze && caps_valid[0]);
endmodule
bind rrcap_capability_regs rrcap_capability_regs_checker rrcap_capability_regs_checker_i (.*);

// ---- testbench/rrcap_remote_model.sv ----
`timescale 1ns/1ps
module rrcap_remote_model
(
   input  wire logic                   ref_clk,
   input  wire logic [1:0]             link_up,
   input  wire logic [3:0]             wait_cycles,
   input  wire rrcap_pkg::rrcap_caps_t word0,
   input  wire rrcap_pkg::rrcap_caps_t word1,
   output rrcap_pkg::rrcap_caps_t      caps_port0,
   output rrcap_pkg::rrcap_caps_t      caps_port1,
   output logic [1:0]                  rx_lock,
   output logic [1:0]                  caps_valid
);
   import rrcap_pkg::*;
   logic [1:0][3:0] cnt_q;
   logic [1:0]      fire;
   initial {rx_lock, caps_valid, cnt_q, caps_port0, caps_port1} = '0;
   // Word toggles outside its valid cycle so a stray load shows
   always @(negedge ref_clk)
   begin
      for (int i = 0; i < 2; i++)
      begin
         fire[i] = rx_lock[i] && link_up[i] && cnt_q[i] == wait_cycles;
         cnt_q[i] <= (rx_lock[i] && link_up[i]) ? cnt_q[i] + {3'h0, cnt_q[i] != 4'hf} : 4'h0;
      end
      caps_valid <= fire;
      rx_lock <= link_up;
      caps_port0 <= fire[0] ? word0 : ~caps_port0;
      caps_port1 <= fire[1] ? word1 : ~caps_port1;
   end
endmodule

// ---- testbench/rrcap_capability_regs_tb.sv ----
`timescale 1ns/1ps
module rrcap_capability_regs_tb;
   import rrcap_pkg::*;
   logic            ref_clk = 1'b0;
   logic            srst = 1'b1;
   rrcap_req_t      req = '0;
   rrcap_rsp_t      rsp;
   logic            second_port_select = 1'b0;
   logic            secondary_address_enable = 1'b0;
   logic [1:0]      link_up = 2'b00;
   logic [3:0]      wait_cycles = 4'h9;
   rrcap_caps_t     word0 = 9'h1a5;
   rrcap_caps_t     word1 = 9'h05a;
   logic [1:0]      rx_lock;
   logic [1:0]      caps_valid;
   rrcap_caps_t     caps_port0;
   rrcap_caps_t     caps_port1;
   rrcap_port_out_t port0_out;
   rrcap_port_out_t port1_out;
   int              failures = 0;
   int              samples_checked = 0;
   int              cycles = 0;
   rrcap_capability_regs rrcap_capability_regs_i (.*);
   rrcap_remote_model rrcap_remote_model_i (.*);
   initial forever #5 ref_clk = ~ref_clk;
   task automatic chk(input string n, input logic [9:0] e, input logic [9:0] s);
      samples_checked++;
      if (s !== e)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d, input logic v);
      @(negedge ref_clk);
      req <= '{a, w, !w, d, v};
      @(negedge ref_clk);
      req <= '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic v, input logic [8:0] e);
      acc(a, 1'b0, 8'h00, v);
      chk("rsp", {1'b0, e}, {1'b0, rsp});
   endtask
   task automatic relink(input logic [1:0] m);
      @(negedge ref_clk);
      link_up <= link_up & ~m;
      repeat (3) @(negedge ref_clk);
      link_up <= link_up | m;
      repeat (16) @(negedge ref_clk);
   endtask
   task automatic tally_and_finish;
      if (failures == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         failures++;
         tally_and_finish();
      end
   end
   initial
   begin
      repeat (6) @(negedge ref_clk);
      srst <= 1'b0;
      rd(8'h20, 1'b0, 9'h100);
      rd(8'h1f, 1'b0, 9'h000);
      relink(2'b11);
      chk("port0_out", {1'b0, word0}, port0_out);
      chk("port1_out", {1'b0, word1}, port1_out);
      rd(8'h21, 1'b0, {7'h40, word0[8:7]});
      second_port_select <= 1'b1;
      rd(8'h20, 1'b0, {2'h2, word1[6:0]});
      secondary_address_enable <= 1'b1;
      acc(8'h20, 1'b1, 8'hc3, 1'b0);
      acc(8'h21, 1'b1, 8'hfe, 1'b0);
      word0 <= 9'h0ff;
      wait_cycles <= 4'h0;
      relink(2'b01);
      chk("port0_out", 10'h343, port0_out);
      rd(8'h20, 1'b0, 9'h1c3);
      rd(8'h21, 1'b1, {7'h40, word1[8:7]});
      for (int c = 0; c < 8; c++)
      begin
         acc(8'h20, 1'b1, {1'b1, c[0], 6'h00}, 1'b1);
         acc(8'h21, 1'b1, {6'h00, c[2:1]}, 1'b1);
         chk("code", {7'h00, c[2:0]}, {7'h00, port1_out.fast_control_channel_code});
      end
      acc(8'h20, 1'b1, 8'h00, 1'b0);
      relink(2'b01);
      chk("port0_out", {1'b0, word0}, port0_out);
      tally_and_finish();
   end
endmodule
